// ---- src/ctmc_regs.svh ----
// Offsets, reset values, field positions and timing counts of the charger control bank
`ifndef CTMC_REGS_SVH
`define CTMC_REGS_SVH

`define CTMC_TERM_OFS      8'h05
`define CTMC_COMP_OFS      8'h06
`define CTMC_MISC_OFS      8'h07

`define CTMC_TERM_RST      8'h9a
`define CTMC_COMP_RST      8'h03
`define CTMC_MISC_RST      8'h4b

`define CTMC_MISC_PD_BIT   7
`define CTMC_MISC_RSV_MASK 8'h0c
`define CTMC_MISC_RSV_VAL  8'h08

`define CTMC_CLK_HZ        10000000
`define CTMC_TICK_S        1
`define CTMC_TICK_CYCLES   (`CTMC_CLK_HZ * `CTMC_TICK_S)

`define CTMC_WDT_40_S      17'd40
`define CTMC_WDT_80_S      17'd80
`define CTMC_WDT_160_S     17'd160
`define CTMC_SEC_PER_HR    17'd3600
`define CTMC_SAFE_5_HR     17'd5
`define CTMC_SAFE_8_HR     17'd8
`define CTMC_SAFE_12_HR    17'd12
`define CTMC_SAFE_20_HR    17'd20

`define CTMC_EARLY_MA      13'd800
`define CTMC_FAST_CHARGE_CURRENT_OFS_MA   13'd512
`define CTMC_FAST_CHARGE_CURRENT_STEP_MA  13'd64
`define CTMC_WARM_LO_MV    13'd4050
`define CTMC_WARM_HI_MV    13'd4200
`define CTMC_COMP_STEP_MO  7'd10
`define CTMC_CLAMP_STEP_MV 7'd16
`define CTMC_DIE_TEMP_LIMIT_BASE_C   7'd60
`define CTMC_DIE_TEMP_LIMIT_STEP_C   7'd20

`endif

// ---- src/ctmc_pkg.sv ----
// Field layouts and state types of the charger control bank
package ctmc_pkg;

   typedef struct packed {
      logic       term_enable;
      logic       early_done_indicator;
      logic [1:0] host_timeout_select;
      logic       safety_timer_enable;
      logic [1:0] fast_charge_time_limit;
      logic       cool_band_current_scale;
   } ctmc_term_t;

   typedef struct packed {
      logic [2:0] ir_comp_resistance;
      logic [2:0] ir_comp_clamp;
      logic [1:0] die_temp_limit;
   } ctmc_comp_t;

   typedef struct packed {
      logic       force_port_detect;
      logic       safety_timer_halfspeed;
      logic       battery_switch_off;
      logic       warm_band_voltage;
      logic [1:0] reserved;
      logic       chg_fault_alert_en;
      logic       battery_overvolt_fault_alert_en;
   } ctmc_misc_t;

   typedef enum logic [0:0] {
      CTMC_PD_IDLE = 1'b0,
      CTMC_PD_BUSY = 1'b1
   } ctmc_pd_state_t;

endpackage : ctmc_pkg

// ---- src/ctmc_timer.sv ----
// Second-based count-up timer used for host timeout and charge safety timer
`timescale 1ns/10ps
module ctmc_timer (
   input  wire logic        core_clk,
   input  wire logic        reset,
   input  wire logic        tick,
   input  wire logic        run,
   input  wire logic [16:0] limit,
   output logic             expired
);

   logic [16:0] count;
   logic [16:0] next_count;
   logic        next_expired;

   // Stopping the run input also restarts the count
   always_comb begin
      next_count   = count;
      next_expired = 1'b0;
      if (!run || limit == 17'h0) begin
         next_count = 17'h0;
      end else if (tick) begin
         if (count + 17'h1 >= limit) begin
            next_count   = 17'h0;
            next_expired = 1'b1;
         end else begin
            next_count = count + 17'h1;
         end
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         count   <= 17'h0;
         expired <= 1'b0;
      end else begin
         count   <= next_count;
         expired <= next_expired;
      end
   end

   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);

   // Limit may shrink under a running count, so expiry is judged against the old limit
   AST_TMR_EXPIRE: assert property (expired |-> $past(run) && $past(tick)
                                    && $past(count) + 17'h1 >= $past(limit))
      else $error("Timer expired before reaching its limit");

endmodule : ctmc_timer

// ---- src/ctmc_control.sv ----
// Termination, timer, compensation and misc control registers of the charger
`timescale 1ns/10ps
`include "ctmc_regs.svh"
//////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Reset loads 0x9a, 0x03 and 0x4b into the three registers.
// - Termination bit enables charge termination; enabled after reset.
// - Indicator shows done at term current, or early below 800 mA.
// - Host timeout select: off, 40 s, 80 s, 160 s; default 40 s.
// - Safety timer enable bit turns the timer on; default on.
// - Safety timer length 5, 8, 12 or 20 hours; default 8.
// - Cool band scales fast charge current to 50 or 20 percent.
// - Compensation resistance weighted 40/20/10 milliohm, 0 to 70.
// - Compensation clamp weighted 64/32/16 mV, 0 to 112.
// - Die temperature limit 60, 80, 100 or 120 C; default 120.
// - Writing 1 starts port detection; hardware clears bit when done.
// - Half speed bit slows safety timer during DPM or thermal regulation.
// - Battery switch off bit forces the battery switch off.
// - Charge fault alert enable gates host alert; default enabled.
// - Battery overvoltage alert enable gates host alert; default enabled.
// - Host timeout expiry raises the host timeout fault.
//////////////////////////////////////////////////////////////////////////////
module ctmc_control #(
   parameter int TICK_CYCLES = `CTMC_TICK_CYCLES
) (
   input  wire logic        core_clk,
   input  wire logic        reset,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   output logic      [7:0]  reg_rdata,
   input  wire logic        charge_done,
   input  wire logic [12:0] charge_current_ma,
   input  wire logic        fast_charging,
   input  wire logic        dpm_active,
   input  wire logic        thermal_reg_active,
   input  wire logic [5:0]  fast_charge_current,
   input  wire logic        in_cool_band,
   input  wire logic        in_warm_band,
   input  wire logic [12:0] charge_voltage_base_mv,
   input  wire logic        port_detect_done,
   input  wire logic [1:0]  charge_fault_code,
   input  wire logic        battery_overvolt_fault,
   output logic             charge_term_enable,
   output logic             charge_indicator_pin,
   output logic             host_timeout_fault,
   output logic             safety_timer_expired,
   output logic      [12:0] charge_current_limit_ma,
   output logic      [12:0] charge_voltage_mv,
   output logic      [6:0]  ir_comp_mohm,
   output logic      [6:0]  ir_comp_clamp_mv,
   output logic      [6:0]  die_temp_limit_c,
   output logic             port_detect_start,
   output logic             battery_switch_off,
   output logic             host_alert_pin
);

   function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
      reg_hit = (addr == ofs);
   endfunction : reg_hit

   //////////////////////////////////////////////////////////////////////////
   // Register file

   ctmc_pkg::ctmc_term_t     term_q;
   ctmc_pkg::ctmc_term_t     next_term;
   ctmc_pkg::ctmc_comp_t     comp_q;
   ctmc_pkg::ctmc_comp_t     next_comp;
   ctmc_pkg::ctmc_misc_t     misc_q;
   ctmc_pkg::ctmc_misc_t     next_misc;
   ctmc_pkg::ctmc_pd_state_t pd_state;
   ctmc_pkg::ctmc_pd_state_t next_pd_state;
   logic [7:0]               next_rdata;
   logic                     next_pd_start;
   logic                     pd_set;

   assign pd_set = reg_wr && reg_hit(reg_addr, `CTMC_MISC_OFS) && reg_wdata[`CTMC_MISC_PD_BIT];

   always_comb begin
      next_term     = term_q;
      next_comp     = comp_q;
      next_misc     = misc_q;
      next_pd_state = pd_state;
      next_pd_start = 1'b0;
      next_rdata    = reg_rdata;
      if (reg_wr && reg_hit(reg_addr, `CTMC_TERM_OFS)) begin
         next_term = ctmc_pkg::ctmc_term_t'(reg_wdata);
      end
      if (reg_wr && reg_hit(reg_addr, `CTMC_COMP_OFS)) begin
         next_comp = ctmc_pkg::ctmc_comp_t'(reg_wdata);
      end
      // Reserved bits keep their fixed pattern whatever the host writes
      if (reg_wr && reg_hit(reg_addr, `CTMC_MISC_OFS)) begin
         next_misc = ctmc_pkg::ctmc_misc_t'((reg_wdata & ~`CTMC_MISC_RSV_MASK) | `CTMC_MISC_RSV_VAL);
      end
      // Writing 0 cannot abort detection; a set in the done cycle wins
      case (pd_state)
         ctmc_pkg::CTMC_PD_IDLE: begin
            if (pd_set) begin
               next_pd_state = ctmc_pkg::CTMC_PD_BUSY;
               next_pd_start = 1'b1;
            end
         end
         ctmc_pkg::CTMC_PD_BUSY: begin
            if (port_detect_done && !pd_set) begin
               next_pd_state = ctmc_pkg::CTMC_PD_IDLE;
            end
         end
         default: begin
            next_pd_state = ctmc_pkg::CTMC_PD_IDLE;
         end
      endcase
      next_misc.force_port_detect = (next_pd_state == ctmc_pkg::CTMC_PD_BUSY);
      if (reg_rd) begin
         if (reg_hit(reg_addr, `CTMC_TERM_OFS)) begin
            next_rdata = term_q;
         end else if (reg_hit(reg_addr, `CTMC_COMP_OFS)) begin
            next_rdata = comp_q;
         end else if (reg_hit(reg_addr, `CTMC_MISC_OFS)) begin
            next_rdata = misc_q;
         end else begin
            next_rdata = 8'h00;
         end
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         term_q            <= ctmc_pkg::ctmc_term_t'(`CTMC_TERM_RST);
         comp_q            <= ctmc_pkg::ctmc_comp_t'(`CTMC_COMP_RST);
         misc_q            <= ctmc_pkg::ctmc_misc_t'(`CTMC_MISC_RST);
         pd_state          <= ctmc_pkg::CTMC_PD_IDLE;
         port_detect_start <= 1'b0;
         reg_rdata         <= 8'h00;
      end else begin
         term_q            <= next_term;
         comp_q            <= next_comp;
         misc_q            <= next_misc;
         pd_state          <= next_pd_state;
         port_detect_start <= next_pd_start;
         reg_rdata         <= next_rdata;
      end
   end

   assign charge_term_enable = term_q.term_enable;
   assign battery_switch_off = misc_q.battery_switch_off;

   //////////////////////////////////////////////////////////////////////////
   // Second tick and timers

   logic [23:0] sec_cnt;
   logic [23:0] next_sec_cnt;
   logic        sec_tick;
   logic        next_sec_tick;
   logic        half_phase;
   logic        next_half_phase;
   logic        slow;
   logic        safe_tick;
   logic [16:0] wdt_limit;
   logic [16:0] safe_limit;

   assign slow      = misc_q.safety_timer_halfspeed && (dpm_active || thermal_reg_active);
   assign safe_tick = sec_tick && (!slow || half_phase);

   always_comb begin
      next_sec_tick   = 1'b0;
      next_sec_cnt    = sec_cnt + 24'h1;
      next_half_phase = half_phase;
      if (sec_cnt == 24'(TICK_CYCLES - 1)) begin
         next_sec_cnt  = 24'h0;
         next_sec_tick = 1'b1;
      end
      if (sec_tick) begin
         next_half_phase = !half_phase;
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         sec_cnt    <= 24'h0;
         sec_tick   <= 1'b0;
         half_phase <= 1'b0;
      end else begin
         sec_cnt    <= next_sec_cnt;
         sec_tick   <= next_sec_tick;
         half_phase <= next_half_phase;
      end
   end

   always_comb begin
      case (term_q.host_timeout_select)
         2'b01:   wdt_limit = `CTMC_WDT_40_S;
         2'b10:   wdt_limit = `CTMC_WDT_80_S;
         2'b11:   wdt_limit = `CTMC_WDT_160_S;
         default: wdt_limit = 17'h0;
      endcase
      case (term_q.fast_charge_time_limit)
         2'b00:   safe_limit = 17'(`CTMC_SAFE_5_HR * `CTMC_SEC_PER_HR);
         2'b01:   safe_limit = 17'(`CTMC_SAFE_8_HR * `CTMC_SEC_PER_HR);
         2'b10:   safe_limit = 17'(`CTMC_SAFE_12_HR * `CTMC_SEC_PER_HR);
         default: safe_limit = 17'(`CTMC_SAFE_20_HR * `CTMC_SEC_PER_HR);
      endcase
   end

   ctmc_timer u_host_timeout (
      .core_clk (core_clk),
      .reset    (reset),
      .tick     (sec_tick),
      .run      (!reg_wr),
      .limit    (wdt_limit),
      .expired  (host_timeout_fault)
   );

   ctmc_timer u_safety_timer (
      .core_clk (core_clk),
      .reset    (reset),
      .tick     (safe_tick),
      .run      (term_q.safety_timer_enable && fast_charging),
      .limit    (safe_limit),
      .expired  (safety_timer_expired)
   );

   //////////////////////////////////////////////////////////////////////////
   // Derived settings, indicator and alert

   logic [12:0] base_ma;
   logic [12:0] next_curr;
   logic [12:0] next_volt;
   logic        next_ind;
   logic        next_alert;
   logic [1:0]  fault_prev;
   logic        ovp_prev;

   assign base_ma = `CTMC_FAST_CHARGE_CURRENT_OFS_MA + 13'(fast_charge_current) * `CTMC_FAST_CHARGE_CURRENT_STEP_MA;

   always_comb begin
      next_curr = base_ma;
      if (in_cool_band) begin
         next_curr = term_q.cool_band_current_scale ? base_ma / 13'd5 : base_ma >> 1;
      end
      next_volt = charge_voltage_base_mv;
      if (in_warm_band) begin
         next_volt = misc_q.warm_band_voltage ? `CTMC_WARM_HI_MV : `CTMC_WARM_LO_MV;
      end
      next_ind = charge_done;
      if (term_q.early_done_indicator && charge_current_ma < `CTMC_EARLY_MA) begin
         next_ind = 1'b1;
      end
      next_alert = (misc_q.chg_fault_alert_en && charge_fault_code != 2'b00
                    && charge_fault_code != fault_prev)
                || (misc_q.battery_overvolt_fault_alert_en && battery_overvolt_fault && !ovp_prev);
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         charge_current_limit_ma <= 13'h0;
         charge_voltage_mv       <= 13'h0;
         ir_comp_mohm            <= 7'h0;
         ir_comp_clamp_mv        <= 7'h0;
         die_temp_limit_c        <= 7'h0;
         charge_indicator_pin    <= 1'b0;
         host_alert_pin          <= 1'b0;
         fault_prev              <= 2'b00;
         ovp_prev                <= 1'b0;
      end else begin
         charge_current_limit_ma <= next_curr;
         charge_voltage_mv       <= next_volt;
         ir_comp_mohm            <= 7'(comp_q.ir_comp_resistance) * `CTMC_COMP_STEP_MO;
         ir_comp_clamp_mv        <= 7'(comp_q.ir_comp_clamp) * `CTMC_CLAMP_STEP_MV;
         die_temp_limit_c        <= `CTMC_DIE_TEMP_LIMIT_BASE_C + 7'(comp_q.die_temp_limit) * `CTMC_DIE_TEMP_LIMIT_STEP_C;
         charge_indicator_pin    <= next_ind;
         host_alert_pin          <= next_alert;
         fault_prev              <= charge_fault_code;
         ovp_prev                <= battery_overvolt_fault;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);

   AST_RESET_DEFAULTS: assert property ($fell(reset) |-> term_q == 8'h9a && comp_q == 8'h03 && misc_q == 8'h4b)
      else $error("Registers not at defaults after reset");
   AST_TERM_WRITE: assert property (reg_wr && reg_addr == 8'h05 |=> charge_term_enable == $past(reg_wdata[7]))
      else $error("Termination enable did not follow write");
   AST_EARLY_IND: assert property (term_q.early_done_indicator && charge_current_ma < 13'd800
                                   |=> charge_indicator_pin)
      else $error("Early indicator not raised below 800 mA");
   AST_WDT_OFF: assert property (term_q.host_timeout_select == 2'b00 [*2] |-> !host_timeout_fault)
      else $error("Host timeout fired while disabled");
   AST_WDT_RESTART: assert property (reg_wr |=> !host_timeout_fault)
      else $error("Host timeout fired right after a write");
   AST_SAFE_OFF: assert property (!term_q.safety_timer_enable [*2] |-> !safety_timer_expired)
      else $error("Safety timer fired while disabled");
   AST_SAFE_SLOW: assert property (sec_tick |-> safe_tick == (half_phase
                                   || !(misc_q.safety_timer_halfspeed && (dpm_active || thermal_reg_active))))
      else $error("Safety timer not slowed");
   AST_COOL_SCALE: assert property (in_cool_band && !term_q.cool_band_current_scale
                                    |=> charge_current_limit_ma
                                        == (13'd512 + 13'($past(fast_charge_current)) * 13'd64) >> 1)
      else $error("Cool band current not halved");
   AST_PD_CLEAR: assert property (pd_state == ctmc_pkg::CTMC_PD_BUSY && port_detect_done && !pd_set
                                  |=> !misc_q.force_port_detect && !port_detect_start)
      else $error("Port detect bit not cleared on completion");
   AST_ALERT_MASK: assert property (host_alert_pin |-> $past(misc_q.chg_fault_alert_en || misc_q.battery_overvolt_fault_alert_en))
      else $error("Alert raised with both sources masked");
   AST_BAT_OFF: assert property (reg_wr && reg_addr == 8'h07 |=> battery_switch_off == $past(reg_wdata[5]))
      else $error("Battery switch off did not follow write");

   COV_PD_CYCLE: cover property (port_detect_start ##[1:20] !misc_q.force_port_detect);
   COV_ALERT: cover property (host_alert_pin);
   COV_SHIP: cover property (reg_wr && reg_addr == 8'h07 && reg_wdata[5] ##1 term_q.host_timeout_select == 2'b00);
   COV_SAFE_EXP: cover property (safety_timer_expired);

endmodule : ctmc_control

// ---- verification/ctmc_host_model.sv ----
// Host-side model that reaches the control bank by single byte reads and writes
`timescale 1ns/10ps
module ctmc_host_model (
   input  wire logic       core_clk,
   output logic            reg_wr,
   output logic            reg_rd,
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata,
   input  wire logic [7:0] reg_rdata
);
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end
   //////////////////////////////////////////////////////////////////////////////
   // Released lines flip so a stale value never looks like a live request
   task automatic release_bus();
      reg_addr = ~reg_addr;
      reg_wdata = ~reg_wdata;
   endtask : release_bus
   // Every byte write also restarts the host timeout count
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge core_clk);
      reg_wr = 1'b0;
      release_bus();
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge core_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge core_clk);
      reg_rd = 1'b0;
      release_bus();
      @(negedge core_clk);
      d = reg_rdata;
   endtask : rd
endmodule : ctmc_host_model

// ---- verification/tb.sv ----
// Self-checking bench for the charger control bank
`timescale 1ns/10ps
module tb;
   logic        core_clk, reset, reg_wr, reg_rd, charge_done, fast_charging, dpm_active;
   logic        thermal_reg_active, in_cool_band, in_warm_band, port_detect_done, battery_overvolt_fault;
   logic        charge_term_enable, charge_indicator_pin, host_timeout_fault, safety_timer_expired;
   logic        port_detect_start, battery_switch_off, host_alert_pin;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, rv;
   logic [12:0] charge_current_ma, charge_voltage_base_mv, charge_current_limit_ma, charge_voltage_mv;
   logic [6:0]  ir_comp_mohm, ir_comp_clamp_mv, die_temp_limit_c;
   logic [5:0]  fast_charge_current;
   logic [1:0]  charge_fault_code;
   int          err_total, tests_run, n_alert, n_start, n_hto, n_safe;

   initial core_clk = 1'b0;
   always #50 core_clk = ~core_clk;

   ctmc_host_model host (.core_clk(core_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

   // Short second tick keeps the hour-long safety timer inside the run
   ctmc_control #(.TICK_CYCLES(2)) dut (.core_clk(core_clk), .reset(reset), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .charge_done(charge_done), .charge_current_ma(charge_current_ma), .fast_charging(fast_charging),
      .dpm_active(dpm_active), .thermal_reg_active(thermal_reg_active),
      .fast_charge_current(fast_charge_current), .in_cool_band(in_cool_band), .in_warm_band(in_warm_band),
      .charge_voltage_base_mv(charge_voltage_base_mv), .port_detect_done(port_detect_done),
      .charge_fault_code(charge_fault_code), .battery_overvolt_fault(battery_overvolt_fault),
      .charge_term_enable(charge_term_enable), .charge_indicator_pin(charge_indicator_pin),
      .host_timeout_fault(host_timeout_fault), .safety_timer_expired(safety_timer_expired),
      .charge_current_limit_ma(charge_current_limit_ma), .charge_voltage_mv(charge_voltage_mv),
      .ir_comp_mohm(ir_comp_mohm), .ir_comp_clamp_mv(ir_comp_clamp_mv), .die_temp_limit_c(die_temp_limit_c),
      .port_detect_start(port_detect_start), .battery_switch_off(battery_switch_off),
      .host_alert_pin(host_alert_pin));

   // Pulses counted on the rising edge, before that edge's updates land
   always @(posedge core_clk) begin
      if (host_alert_pin === 1'b1) n_alert++;
      if (port_detect_start === 1'b1) n_start++;
      if (host_timeout_fault === 1'b1) n_hto++;
      if (safety_timer_expired === 1'b1) n_safe++;
   end
   //////////////////////////////////////////////////////////////////////////////
   task automatic end_sim();
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk);
   endtask : cyc
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      host.rd(a, rv);
      chk(rv, e);
   endtask : rchk
   task automatic alert(input logic [7:0] m, input logic [1:0] c, input logic o, input int inc);
      host.wr(8'h07, m);
      n_alert = 0;
      charge_fault_code = c;
      battery_overvolt_fault = o;
      cyc(3);
      chk(16'(n_alert), 16'(inc));
   endtask : alert
   // Silent just before the period, at least one pulse shortly after it
   task automatic hto(input logic [1:0] s, input int per);
      host.wr(8'h05, {2'b10, s, 4'h2});
      n_hto = 0;
      cyc(per - 20);
      chk(16'(n_hto), 16'h0000);
      cyc(60);
      chk(16'(n_hto != 0), 16'h0001);
   endtask : hto
   //////////////////////////////////////////////////////////////////////////////
   initial begin
      #10ms;
      err_total++;
      end_sim();
   end
   initial begin
      reset = 1'b1;
      charge_done = 1'b0;
      charge_current_ma = 13'd2000;
      fast_charging = 1'b0;
      dpm_active = 1'b0;
      thermal_reg_active = 1'b0;
      fast_charge_current = 6'h18;
      in_cool_band = 1'b0;
      in_warm_band = 1'b0;
      charge_voltage_base_mv = 13'd4208;
      port_detect_done = 1'b0;
      charge_fault_code = 2'h0;
      battery_overvolt_fault = 1'b0;
      repeat (3) @(negedge core_clk);
      reset = 1'b0;
      cyc(2);
      rchk(8'h05, 8'h9a);
      rchk(8'h06, 8'h03);
      rchk(8'h07, 8'h4b);
      rchk(8'h08, 8'h00);
      chk(charge_term_enable, 16'h0001);
      chk(battery_switch_off, 16'h0000);
      chk(die_temp_limit_c, 16'd120);
      chk(charge_current_limit_ma, 16'd2048);
      chk(charge_voltage_mv, 16'd4208);
      for (int i = 0; i < 8; i++) begin
         host.wr(8'h06, {i[2:0], i[2:0], i[1:0]});
         cyc(2);
         chk(ir_comp_mohm, 16'(i * 10));
         chk(ir_comp_clamp_mv, 16'(i * 16));
         chk(die_temp_limit_c, 16'(60 + 20 * (i % 4)));
      end
      host.wr(8'h05, 8'h00);
      cyc(2);
      chk(charge_term_enable, 16'h0000);
      rchk(8'h05, 8'h00);
      in_cool_band = 1'b1;
      cyc(2);
      chk(charge_current_limit_ma, 16'd1024);
      host.wr(8'h05, 8'h01);
      cyc(2);
      chk(charge_current_limit_ma, 16'd409);
      in_cool_band = 1'b0;
      charge_current_ma = 13'd700;
      cyc(2);
      chk(charge_indicator_pin, 16'h0000);
      host.wr(8'h05, 8'h41);
      cyc(2);
      chk(charge_indicator_pin, 16'h0001);
      charge_current_ma = 13'd900;
      cyc(2);
      chk(charge_indicator_pin, 16'h0000);
      charge_done = 1'b1;
      cyc(2);
      chk(charge_indicator_pin, 16'h0001);
      charge_done = 1'b0;
      in_warm_band = 1'b1;
      cyc(2);
      chk(charge_voltage_mv, 16'd4050);
      host.wr(8'h07, 8'h34);
      cyc(2);
      chk(charge_voltage_mv, 16'd4200);
      chk(battery_switch_off, 16'h0001);
      rchk(8'h07, 8'h38);
      in_warm_band = 1'b0;
      n_start = 0;
      host.wr(8'h07, 8'hcb);
      cyc(2);
      chk(16'(n_start), 16'h0001);
      rchk(8'h07, 8'hcb);
      host.wr(8'h07, 8'hcb);
      cyc(2);
      chk(16'(n_start), 16'h0001);
      port_detect_done = 1'b1;
      cyc(1);
      port_detect_done = 1'b0;
      cyc(2);
      rchk(8'h07, 8'h4b);
      alert(8'h4b, 2'h1, 1'b0, 1);
      alert(8'h49, 2'h2, 1'b0, 0);
      alert(8'h49, 2'h2, 1'b1, 1);
      alert(8'h48, 2'h2, 1'b0, 0);
      alert(8'h48, 2'h2, 1'b1, 0);
      alert(8'h4b, 2'h0, 1'b0, 0);
      // Unmapped writes still count as host activity
      host.wr(8'h05, 8'h92);
      n_hto = 0;
      repeat (4) begin
         cyc(50);
         host.wr(8'h10, 8'h5a);
      end
      chk(16'(n_hto), 16'h0000);
      rchk(8'h10, 8'h00);
      hto(2'b01, 80);
      hto(2'b10, 160);
      hto(2'b11, 320);
      host.wr(8'h05, 8'h88);
      host.wr(8'h07, 8'h6b);
      n_hto = 0;
      n_safe = 0;
      fast_charging = 1'b1;
      cyc(35000);
      chk(16'(n_safe), 16'h0000);
      cyc(2000);
      chk(16'(n_safe), 16'h0001);
      fast_charging = 1'b0;
      cyc(2);
      thermal_reg_active = 1'b1;
      fast_charging = 1'b1;
      n_safe = 0;
      cyc(40000);
      chk(16'(n_safe), 16'h0000);
      chk(16'(n_hto), 16'h0000);
      chk(battery_switch_off, 16'h0001);
      fast_charging = 1'b0;
      end_sim();
   end
endmodule : tb
